//--- psosc_core.sv
// Purpose: pin enables, adc sync select, compares and events of a
//          three-module power stage controller
// Assumes: counter and fault inputs come from logic on core_clk_i
// Notes:   apb slave, one access cycle, no wait states
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module psosc_core #(
    parameter int CMP_W = 12                     // compare width
) (
    input  wire logic                  core_clk_i,      // core clock
    input  wire logic                  srst_i,          // sync reset
    input  wire logic                  psel_i,          // apb select
    input  wire logic                  penable_i,       // apb enable
    input  wire logic                  pwrite_i,        // apb direction
    input  wire logic [7:0]            paddr_i,         // apb address
    input  wire logic [31:0]           pwdata_i,        // apb write data
    output logic      [31:0]           prdata_o,        // apb read data
    output logic                       pready_o,        // apb ready
    output logic                       pslverr_o,       // apb error
    input  psosc_pkg::psosc_cnt_t [2:0] cnt_i,          // module counters
    input  psosc_pkg::psosc_flt_t [2:0] flt_i,          // module fault events
    input  wire logic [5:0]            gpio_do_i,       // port data
    input  wire logic [5:0]            gpio_oe_i,       // port enable
    output logic      [5:0]            pin_do_o,        // pin data
    output logic      [5:0]            pin_oe_o,        // pin enable
    output logic      [2:0]            adc_sync_o,      // adc sync pulses
    output logic                       cycle_end_irq_o, // end irq
    output logic                       fault_irq_o,     // fault irq
    output logic      [15:0]           irq_vec_o        // pending vector
);
    localparam int NMOD = psosc_pkg::NMOD;
    localparam int NCMP = psosc_pkg::NCMP;

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    // the high byte must carry at least one bit and fit in the temp
    if (CMP_W < 9 || CMP_W > 16 || CMP_W > $bits(cnt_i[0].val)) begin : g_chk
        $error("CMP_W must be 9..12");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]       pin_en_r;                 // output_pin_enables
    logic [7:0]       sync_sel_r;               // adc_sync_select
    logic             mode_r;                   // ramp_mode_sel
    logic [3:0]       irq_en_r;                 // end + fault enables
    logic             eoc_flag_r;               // cycle_end_flag
    logic [2:0]       flt_flag_r;               // per-module fault flag
    logic [7:0]       temp_hi_r;                // shared high byte
    logic [CMP_W-1:0] cmp_r [NMOD][NCMP];       // compare values
    logic [NMOD-1:0]  wave_a_r;                 // wave_out_a
    logic [NMOD-1:0]  wave_b_r;                 // wave_out_b
    logic [31:0]      prdata_r;                 // read data
    logic             pready_r;                 // access phase ready
    logic             pslverr_r;                // unmapped answer
    logic [5:0]       pin_do_r;                 // pin data
    logic [5:0]       pin_oe_r;                 // pin enable
    logic [2:0]       adc_sync_r;               // sync pulses
    logic             end_irq_r;                // end irq line
    logic             flt_irq_r;                // fault irq line
    logic [15:0]      vec_r;                    // vector code

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // compare byte address: module, compare index, low-byte flag
    function automatic logic [4:0] cmp_loc(input logic [7:0] a);
        logic [7:0] o;
        o = a - psosc_pkg::OFF_CMP_BASE;
        return {o[6:5], o[4:3], o[2]};
    endfunction : cmp_loc

    wire        setup_ph  = psel_i & ~penable_i;          // setup cycle
    wire        acc_wr    = psel_i & penable_i & pready_r & pwrite_i;
    wire        in_cmp    = paddr_i >= psosc_pkg::OFF_CMP_BASE
                          && paddr_i <= psosc_pkg::OFF_CMP_LAST
                          && paddr_i[1:0] == 2'h0;
    wire [4:0]  loc       = cmp_loc(paddr_i);
    wire [1:0]  loc_mod   = loc[4:3];
    wire [1:0]  loc_cmp   = loc[2:1];
    wire        loc_lo    = loc[0];
    wire        cmp_hit   = in_cmp && loc_mod < 2'(NMOD);
    wire        hit_pin   = paddr_i == psosc_pkg::OFF_PIN_EN;
    wire        hit_sync  = paddr_i == psosc_pkg::OFF_SYNC_SEL;
    wire        hit_mode  = paddr_i == psosc_pkg::OFF_MODE;
    wire        hit_ien   = paddr_i == psosc_pkg::OFF_IRQ_EN;
    wire        hit_flag  = paddr_i == psosc_pkg::OFF_IRQ_FLAG;
    wire        hit_vec   = paddr_i == psosc_pkg::OFF_VEC;
    wire        mapped    = hit_pin | hit_sync | hit_mode | hit_ien
                          | hit_flag | hit_vec | cmp_hit;
    wire        wr_hi     = acc_wr & cmp_hit & ~loc_lo;
    wire        wr_lo     = acc_wr & cmp_hit & loc_lo;
    // value committed by a low-byte write: temp high bits + low byte
    wire [CMP_W-1:0] commit_val = {temp_hi_r[CMP_W-9:0], pwdata_i[7:0]};

    // read selection; compare high byte shows the stored upper bits
    wire [CMP_W-1:0] cmp_rd = cmp_r[loc_mod][loc_cmp];
    wire [31:0] rd_data =
        hit_pin  ? {24'h0, pin_en_r} :
        hit_sync ? {24'h0, sync_sel_r} :
        hit_mode ? {31'h0, mode_r} :
        hit_ien  ? {28'h0, irq_en_r} :
        hit_flag ? {28'h0, flt_flag_r, eoc_flag_r} :
        hit_vec  ? {16'h0, vec_r} :
        cmp_hit  ? (loc_lo ? {24'h0, cmp_rd[7:0]}
                           : {24'h0, 8'(cmp_rd[CMP_W-1:8])}) :
        32'h0;

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    // data is captured at setup so every output comes from a flop
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r  <= setup_ph;
            pslverr_r <= setup_ph & ~mapped;
            prdata_r  <= (setup_ph & ~pwrite_i) ? rd_data : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // pin enable bit 2k is part a, 2k+1 part b; bits 7:6 unused
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pin_en_r   <= psosc_pkg::PIN_EN_RST;
            sync_sel_r <= psosc_pkg::SYNC_RST;
            mode_r     <= 1'b0;
            irq_en_r   <= psosc_pkg::IRQ_EN_RST;
        end else if (acc_wr) begin
            if (hit_pin) begin
                pin_en_r <= {2'h0, pwdata_i[5:0]};
            end
            if (hit_sync) begin
                sync_sel_r <= pwdata_i[7:0];
            end
            if (hit_mode) begin
                mode_r <= pwdata_i[psosc_pkg::MODE_BIT];
            end
            if (hit_ien) begin
                irq_en_r <= pwdata_i[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // shared temporary high byte and compare commit
    // ------------------------------------------------------------
    // one temp for all compares, so interleaving two high writes loses
    // the first; software must pair high then low per register
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            temp_hi_r <= 8'h00;
        end else if (wr_hi) begin
            temp_hi_r <= pwdata_i[7:0];
        end
    end

    // both bytes land in the same cycle on the low write
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            for (int m = 0; m < NMOD; m++) begin
                for (int c = 0; c < NCMP; c++) begin
                    cmp_r[m][c] <= '0;
                end
            end
        end else if (wr_lo) begin
            cmp_r[loc_mod][loc_cmp] <= commit_val;
        end
    end

    // ------------------------------------------------------------
    // per-module compare, waveform and sync
    // ------------------------------------------------------------
    // sync selection per mode; centered 10/11 never pulses
    function automatic logic sync_pick(input logic       cent,
                                       input logic [1:0] sel,
                                       input logic [5:0] ev);
        // ev: {ra_up, ra_down, b_trail, b_lead, a_trail, a_lead}
        logic r;
        r = 1'b0;
        if (!cent) begin
            unique case (sel)
                psosc_pkg::SYN_0: r = ev[0];
                psosc_pkg::SYN_1: r = ev[1];
                psosc_pkg::SYN_2: r = ev[2];
                psosc_pkg::SYN_3: r = ev[3];
            endcase
        end else begin
            unique case (sel)
                psosc_pkg::SYN_0: r = ev[4];
                psosc_pkg::SYN_1: r = ev[5];
                psosc_pkg::SYN_2: r = 1'b0;
                psosc_pkg::SYN_3: r = 1'b0;
            endcase
        end
        return r;
    endfunction : sync_pick

    logic [NCMP-1:0] match [NMOD];               // compare hits per count
    logic [NMOD-1:0] flt_ev;                     // any fault per module

    for (genvar m = 0; m < NMOD; m++) begin : g_mod
        for (genvar c = 0; c < NCMP; c++) begin : g_cmp
            // compared on each new counter value only
            assign match[m][c] = cnt_i[m].tick
                && cnt_i[m].val[CMP_W-1:0] == cmp_r[m][c];
        end
        wire a_lead  = match[m][psosc_pkg::CMP_SA];
        wire a_trail = match[m][psosc_pkg::CMP_RA] | flt_i[m].fault_a;
        wire b_lead  = match[m][psosc_pkg::CMP_SB];
        wire b_trail = match[m][psosc_pkg::CMP_RB] | flt_i[m].fault_b;
        wire ra_dn   = match[m][psosc_pkg::CMP_RA] & cnt_i[m].down;
        wire ra_up   = match[m][psosc_pkg::CMP_RA] & ~cnt_i[m].down;
        wire [5:0] ev = {ra_up, ra_dn, b_trail, b_lead, a_trail, a_lead};
        assign flt_ev[m] = flt_i[m].fault_a | flt_i[m].fault_b;
        wire [1:0] sel = sync_sel_r[2*m +: psosc_pkg::SYNC_W];
        wire en_a = pin_en_r[2*m];
        wire en_b = pin_en_r[2*m+1];

        // waveforms: set on set match, clear wins on reset or fault
        always_ff @(posedge core_clk_i) begin
            if (srst_i) begin
                wave_a_r[m] <= 1'b0;
                wave_b_r[m] <= 1'b0;
            end else begin
                wave_a_r[m] <= ~a_trail & (a_lead | wave_a_r[m]);
                wave_b_r[m] <= ~b_trail & (b_lead | wave_b_r[m]);
            end
        end

        // pins: waveform when enabled, plain port otherwise
        always_ff @(posedge core_clk_i) begin
            if (srst_i) begin
                pin_do_r[2*m +: 2] <= 2'h0;
                pin_oe_r[2*m +: 2] <= 2'h0;
                adc_sync_r[m]      <= 1'b0;
            end else begin
                pin_do_r[2*m]   <= en_a ? wave_a_r[m] : gpio_do_i[2*m];
                pin_oe_r[2*m]   <= en_a | gpio_oe_i[2*m];
                pin_do_r[2*m+1] <= en_b ? wave_b_r[m] : gpio_do_i[2*m+1];
                pin_oe_r[2*m+1] <= en_b | gpio_oe_i[2*m+1];
                adc_sync_r[m]   <= sync_pick(mode_r, sel, ev);
            end
        end
    end

    // ------------------------------------------------------------
    // event flags, interrupt lines and vector
    // ------------------------------------------------------------
    // module 0 counter defines the end of the whole cycle
    wire       eoc_ev   = match[0][psosc_pkg::CMP_RB];
    wire       clr_wr   = acc_wr & hit_flag;
    wire       eoc_nxt  = eoc_ev | (eoc_flag_r
                        & ~(clr_wr & pwdata_i[psosc_pkg::EOC_BIT]));
    wire [2:0] flt_nxt  = flt_ev | (flt_flag_r
                        & ~({3{clr_wr}} & pwdata_i[psosc_pkg::FLT_LSB +: 3]));
    wire       end_req  = eoc_nxt & irq_en_r[psosc_pkg::EOC_BIT];
    wire       flt_req  = |(flt_nxt & irq_en_r[psosc_pkg::FLT_LSB +: 3]);

    // a set in the cycle of its clear wins, so no event is lost
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            eoc_flag_r <= 1'b0;
            flt_flag_r <= 3'h0;
            end_irq_r  <= 1'b0;
            flt_irq_r  <= 1'b0;
            vec_r      <= psosc_pkg::VEC_NONE;
        end else begin
            eoc_flag_r <= eoc_nxt;
            flt_flag_r <= flt_nxt;
            end_irq_r  <= end_req;
            flt_irq_r  <= flt_req;
            // fault has the lower vector number and is served first
            vec_r <= flt_req ? psosc_pkg::VEC_FAULT :
                     end_req ? psosc_pkg::VEC_END : psosc_pkg::VEC_NONE;
        end
    end

    assign prdata_o        = prdata_r;
    assign pready_o        = pready_r;
    assign pslverr_o       = pslverr_r;
    assign pin_do_o        = pin_do_r;
    assign pin_oe_o        = pin_oe_r;
    assign adc_sync_o      = adc_sync_r;
    assign cycle_end_irq_o = end_irq_r;
    assign fault_irq_o     = flt_irq_r;
    assign irq_vec_o       = vec_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    sequence s_eoc_hit;
        eoc_ev && irq_en_r[0];
    endsequence
    sequence s_lo_commit;
        wr_lo && loc_mod == 2'h0 && loc_cmp == psosc_pkg::CMP_SA;
    endsequence

    property p_end_irq;
        s_eoc_hit |=> eoc_flag_r && cycle_end_irq_o;
    endproperty
    a_end_irq: assert property (p_end_irq) else $error("end irq missed");
    property p_flt_irq;
        flt_ev[1] && irq_en_r[2] |=> fault_irq_o && flt_flag_r[1];
    endproperty
    a_flt_irq: assert property (p_flt_irq) else $error("fault irq missed");
    property p_vec;
        fault_irq_o |-> irq_vec_o == psosc_pkg::VEC_FAULT;
    endproperty
    a_vec: assert property (p_vec) else $error("fault vector wrong");
    property p_pin_port;
        !pin_en_r[0] |=> pin_do_o[0] == $past(gpio_do_i[0]);
    endproperty
    a_pin_port: assert property (p_pin_port) else $error("port pin wrong");
    property p_pin_wave;
        pin_en_r[3] && $stable(pin_en_r) |=> pin_do_o[3] == $past(wave_b_r[1])
            && pin_oe_o[3];
    endproperty
    a_pin_wave: assert property (p_pin_wave) else $error("wave pin wrong");
    property p_sync_lead;
        !mode_r && sync_sel_r[1:0] == 2'h0 && match[0][0] |=> adc_sync_o[0];
    endproperty
    a_sync_lead: assert property (p_sync_lead) else $error("sync lost");
    property p_sync_off;
        mode_r && sync_sel_r[5] |=> !adc_sync_o[2];
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("stray sync");
    property p_commit;
        s_lo_commit |=> cmp_r[0][0] == $past(commit_val);
    endproperty
    a_commit: assert property (p_commit) else $error("compare not committed");
    property p_hi_only;
        wr_hi |=> temp_hi_r == $past(pwdata_i[7:0]) && $stable(cmp_r[0][0]);
    endproperty
    a_hi_only: assert property (p_hi_only) else $error("high write leaked");
    property p_set_wins;
        eoc_ev && clr_wr && pwdata_i[0] |=> eoc_flag_r;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag lost");
endmodule : psosc_core

//--- psosc_core_tb.sv
// Purpose: self-checking bench of the power stage sync/config slice
// Assumes: apb answer comes within the timeout
// Notes:   random data from an lfsr seeded with 32'hE2F2
`timescale 1ns/1ps
module psosc_core_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pw = 1'b0, pr, e, ie, fi;
    logic [7:0] pa = 8'h00;
    logic [31:0] wd = 32'h0, rd, q, rnd = 32'hE2F2;
    logic [5:0] gdo = 6'h00, goe = 6'h00, pdo, poe, en;
    logic [2:0] sync;
    logic [15:0] vec;
    logic [11:0] cv [12];
    int error_cnt = 0, cmp_count = 0, cyc = 0, scnt = 0, s0;
    psosc_pkg::psosc_cnt_t [2:0] cnt;
    psosc_pkg::psosc_flt_t [2:0] flt;
    psosc_far_model u_far (.core_clk_i(clk), .cnt_o(cnt), .flt_o(flt));
    psosc_core u_dut (.core_clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pw), .paddr_i(pa), .pwdata_i(wd), .prdata_o(rd), .pready_o(pr),
        .pslverr_o(e), .cnt_i(cnt), .flt_i(flt), .gpio_do_i(gdo), .gpio_oe_i(goe),
        .pin_do_o(pdo), .pin_oe_o(poe), .adc_sync_o(sync), .cycle_end_irq_o(ie),
        .fault_irq_o(fi), .irq_vec_o(vec));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial forever #5 clk = ~clk;
    // counts module 0 sync pulses; also cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (sync[0] === 1'b1) scnt++;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [7:0] ca(input int m, input int c, input bit hi);
        return 8'(psosc_pkg::OFF_CMP_BASE + m * 32 + c * 8 + (hi ? 0 : 4));
    endfunction : ca
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // setup then access; request held until pready sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pw, pa, wd} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pr !== 1'b1);
        q = e ? 32'hFFFFFFFF : rd;
        {psel, pen} <= 2'b00;
    endtask : apb
    task automatic setc(input int m, input int c, input logic [11:0] v);
        apb(1'b1, ca(m, c, 1), {28'h0, v[11:8]});
        apb(1'b1, ca(m, c, 0), {24'h0, v[7:0]});
    endtask : setc
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, psosc_pkg::OFF_SYNC_SEL, 32'h0);
        chk("sync rst", 32'h0, q);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            en = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : rnd[5:0];
            apb(1'b1, psosc_pkg::OFF_PIN_EN, {24'h0, rnd[7:6], en});
            {gdo, goe} <= rnd[19:8];
            repeat (3) @(posedge clk);
            chk("pin_oe", 32'(en | (goe & ~en)), 32'(poe));
            chk("pin_do", 32'(gdo & ~en), 32'(pdo & ~en));
            apb(1'b0, psosc_pkg::OFF_PIN_EN, 32'h0);
            chk("pin_en rd", 32'(en), q);
        end
        $display("test pins done");
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            cv[i] = rnd[11:0];
            setc(i / 4, i % 4, cv[i]);
            apb(1'b0, ca(i / 4, i % 4, 1), 32'h0);
            chk("cmp hi", 32'(cv[i][11:8]), q);
            apb(1'b0, ca(i / 4, i % 4, 0), 32'h0);
            chk("cmp lo", 32'(cv[i][7:0]), q);
        end
        apb(1'b1, ca(0, 0, 1), 32'h0000000A);
        apb(1'b1, ca(2, 3, 0), 32'h0000005C);
        apb(1'b0, ca(2, 3, 1), 32'h0);
        chk("shared temp", 32'hA, q);
        apb(1'b0, ca(0, 0, 1), 32'h0);
        chk("hi only temp", 32'(cv[0][11:8]), q);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", 32'hFFFFFFFF, q);
        $display("test compares done");
        apb(1'b1, psosc_pkg::OFF_IRQ_EN, 32'h0000000F);
        setc(0, 3, 12'h123);
        u_far.tick(0, 12'h123, 1'b0);
        repeat (3) @(posedge clk);
        chk("end irq", {31'h0, 1'b1}, {31'h0, ie});
        chk("vec end", 32'(psosc_pkg::VEC_END), 32'(vec));
        u_far.fault(1);
        repeat (3) @(posedge clk);
        chk("fault irq", {31'h0, 1'b1}, {31'h0, fi});
        chk("vec fault", 32'(psosc_pkg::VEC_FAULT), 32'(vec));
        apb(1'b1, psosc_pkg::OFF_IRQ_EN, 32'h0);
        u_far.tick(0, 12'h123, 1'b0);
        repeat (3) @(posedge clk);
        chk("irq masked", 32'h0, {30'h0, ie, fi});
        apb(1'b0, psosc_pkg::OFF_IRQ_FLAG, 32'h0);
        chk("flags", 32'h5, q);
        apb(1'b1, psosc_pkg::OFF_IRQ_FLAG, 32'h0000000F);
        apb(1'b0, psosc_pkg::OFF_IRQ_FLAG, 32'h0);
        chk("flags w1c", 32'h0, q);
        // end event lands on the clear edge; the set has to survive it
        fork
            apb(1'b1, psosc_pkg::OFF_IRQ_FLAG, 32'h00000001);
            begin
                @(posedge clk);
                u_far.tick(0, 12'h123, 1'b0);
            end
        join
        apb(1'b0, psosc_pkg::OFF_IRQ_FLAG, 32'h0);
        chk("set wins", 32'h1, q);
        $display("test events done");
        apb(1'b1, psosc_pkg::OFF_PIN_EN, 32'h0000003F);
        for (int c = 0; c < 4; c++) setc(0, c, 12'(16 * (c + 1)));
        for (int md = 0; md < 2; md++) for (int s = 0; s < 4; s++) begin
            apb(1'b1, psosc_pkg::OFF_MODE, 32'(md));
            apb(1'b1, psosc_pkg::OFF_SYNC_SEL, 32'(s) * 32'h15);
            s0 = scnt;
            for (int c = 0; c < 4 && md == 0; c++) begin
                u_far.tick(0, 12'(16 * (c + 1)), 1'b0);
                repeat (3) @(posedge clk);
                if (c == 0) chk("wave a", 32'h1, 32'(pdo[0]));
            end
            if (md == 1) for (int d = 1; d >= 0; d--) u_far.tick(0, 12'h020, d[0]);
            repeat (3) @(posedge clk);
            chk("sync", 32'(md == 0 || s < 2), 32'(scnt - s0));
        end
        $display("test sync done");
        results();
    end
endmodule : psosc_core_tb

//--- psosc_far_model.sv
// Purpose: far side model, module counters and fault inputs
// Assumes: all pulses launched just after a core_clk_i rising edge
// Notes:   ticks and faults last exactly one cycle
`timescale 1ns/1ps
module psosc_far_model (
    input  wire logic                   core_clk_i, // core clock
    output psosc_pkg::psosc_cnt_t [2:0] cnt_o,      // module counters
    output psosc_pkg::psosc_flt_t [2:0] flt_o       // fault pulses
);
    // ------------------------------------------------------------
    // stimulus tasks
    // ------------------------------------------------------------
    initial cnt_o = '0;
    initial flt_o = '0;
    // one counted value; value inverted after so a stale match can't hide
    task automatic tick(input int m, input logic [11:0] v, input logic dn);
        @(posedge core_clk_i);
        cnt_o[m] <= {1'b1, dn, v};
        @(posedge core_clk_i);
        cnt_o[m] <= {1'b0, dn, ~v};
    endtask : tick
    // fault event on part a of module m
    task automatic fault(input int m);
        @(posedge core_clk_i);
        flt_o[m].fault_a <= 1'b1;
        @(posedge core_clk_i);
        flt_o[m].fault_a <= 1'b0;
    endtask : fault
endmodule : psosc_far_model

//--- psosc_pkg.sv
// Purpose: shared constants and carriers of the power stage sync/config slice
// Assumes: 32-bit APB, one register per aligned word
// Notes:   offsets are byte addresses on the APB bus
package psosc_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NMOD  = 3;            // identical waveform modules
    localparam int NCMP  = 4;            // compare registers per module
    localparam int NPIN  = 2 * NMOD;     // two waveform pins per module
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PIN_EN   = 8'h00; // output_pin_enables
    localparam logic [7:0] OFF_SYNC_SEL = 8'h04; // adc_sync_select
    localparam logic [7:0] OFF_MODE     = 8'h08; // ramp mode
    localparam logic [7:0] OFF_IRQ_EN   = 8'h0C; // interrupt enables
    localparam logic [7:0] OFF_IRQ_FLAG = 8'h10; // interrupt flags, w1c
    localparam logic [7:0] OFF_VEC      = 8'h14; // pending vector, ro
    localparam logic [7:0] OFF_CMP_BASE = 8'h20; // first compare byte
    localparam logic [7:0] OFF_CMP_LAST = 8'h7C; // last compare byte
    // compare window: module*0x20 + cmp*0x08 + {0:high,4:low}
    localparam logic [7:0] CMP_MOD_STEP = 8'h20;
    // ------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] PIN_EN_RST = 8'h00;
    localparam logic [7:0] SYNC_RST   = 8'h00;
    localparam logic [3:0] IRQ_EN_RST = 4'h0;
    localparam int         EOC_BIT    = 0;   // end-of-cycle flag/enable
    localparam int         FLT_LSB    = 1;   // fault flags/enables 3:1
    localparam int         MODE_BIT   = 0;   // 0 one-ramp, 1 centered
    localparam int         SYNC_W     = 2;   // selector width per module
    // ------------------------------------------------------------
    // compare index and sync selector codes
    // ------------------------------------------------------------
    localparam logic [1:0] CMP_SA = 2'h0;
    localparam logic [1:0] CMP_RA = 2'h1;
    localparam logic [1:0] CMP_SB = 2'h2;
    localparam logic [1:0] CMP_RB = 2'h3;
    localparam logic [1:0] SYN_0  = 2'h0;
    localparam logic [1:0] SYN_1  = 2'h1;
    localparam logic [1:0] SYN_2  = 2'h2;
    localparam logic [1:0] SYN_3  = 2'h3;
    // ------------------------------------------------------------
    // interrupt vectors (program addresses)
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_FAULT = 16'h0004;
    localparam logic [15:0] VEC_END   = 16'h0005;
    localparam logic [15:0] VEC_NONE  = 16'h0000;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        tick;               // counter took a new value
        logic        down;               // counting down (centered)
        logic [11:0] val;                // counter value
    } psosc_cnt_t;
    typedef struct packed {
        logic fault_a;                   // fault/retrigger on part a
        logic fault_b;                   // fault/retrigger on part b
    } psosc_flt_t;
endpackage : psosc_pkg
